/* File: lps_top.sv */
// register set, two-wire target and threshold interrupt of the light/proximity sensor
// Function
// - light control 0x03 starts free-running light
// - light rate 0x00 gives result every 100ms
// - lower light threshold 16 bit at 0x98/0x99
// - upper light threshold 16 bit at 0x96/0x97
// - proximity control 0x03 starts free-running proximity
// - proximity rate 0x00 gives result every 10ms
// - proximity threshold byte at 0x93 raises event
// - setup 0x03 enables proximity and light interrupts
// - setup 0x03 gives latched active-low interrupt
// - status 0x8E shows light caused interrupt
// - light result low 0x8C, high 0x8D
// - proximity result readable at 0x8F
// - proximity code is logarithmic irradiance code
// - default light interrupt outside threshold window
// - inversion means inside window, non-latched only
// - proximity interrupt on approach, inverted recedes
`timescale 1ns/1ns
module lps_top #(
  parameter int unsigned LIGHT_PERIOD_CYC = lps_pkg::LIGHT_PERIOD_CYC,
  parameter int unsigned PROX_PERIOD_CYC = lps_pkg::PROX_PERIOD_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // open-drain interrupt pin
  output logic int_n_out,
  output logic int_n_oe,
  // converter side
  input wire logic [15:0] light_sample,
  input wire logic [7:0] prox_sample,
  output logic light_conv_start,
  output logic prox_conv_start,
  output logic [7:0] emitter_current
);
  // register storage
  logic [7:0] light_ctrl_reg;
  logic [7:0] prox_ctrl_reg;
  logic [7:0] emit_cfg_reg;
  logic [7:0] prox_rate_reg;
  logic [7:0] light_rate_reg;
  logic [7:0] int_setup_reg;
  logic [7:0] prox_thr_reg;
  logic [15:0] light_upper_reg;
  logic [15:0] light_lower_reg;
  logic [15:0] light_result_reg;
  logic [7:0] prox_result_reg;
  logic stat_light_reg;
  logic stat_prox_reg;
  logic light_start_reg;
  logic prox_start_reg;
  // serial engine
  lps_pkg::lps_i2c_state_t state_reg;
  lps_pkg::lps_i2c_state_t after_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic got_reg;
  logic sda_drive_reg;
  logic [7:0] index_reg;
  logic scl_q_reg;
  logic sda_q_reg;
  logic wr_pulse_reg;
  logic [7:0] wr_idx_reg;
  logic [7:0] wr_data_reg;
  logic status_read;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] rd_byte;
  // interrupt evaluation
  logic transparent;
  logic invert_eff;
  logic light_outside;
  logic light_hit;
  logic prox_hit;
  logic light_tick;
  logic prox_tick;

  lps_meas_if meas ();

  lps_meas_sched #(
    .LIGHT_CYC(LIGHT_PERIOD_CYC),
    .PROX_CYC(PROX_PERIOD_CYC)
  ) u_sched (
    .core_clk(core_clk),
    .nrst(nrst),
    .meas(meas)
  );

  function automatic logic is_free_run(input logic [7:0] ctrl);
    is_free_run = (ctrl[lps_pkg::MODE_LSB +: lps_pkg::MODE_W] == lps_pkg::MODE_FREE_RUN);
  endfunction : is_free_run

  function automatic logic [7:0] reg_read(input logic [7:0] idx);
    unique case (idx)
      lps_pkg::OFS_LIGHT_CTRL: reg_read = light_ctrl_reg;
      lps_pkg::OFS_PROX_CTRL: reg_read = prox_ctrl_reg;
      lps_pkg::OFS_EMIT_CFG: reg_read = emit_cfg_reg;
      lps_pkg::OFS_PROX_RATE: reg_read = prox_rate_reg;
      lps_pkg::OFS_LIGHT_RATE: reg_read = light_rate_reg;
      lps_pkg::OFS_LRES_LO: reg_read = light_result_reg[7:0];
      lps_pkg::OFS_LRES_HI: reg_read = light_result_reg[15:8];
      lps_pkg::OFS_STATUS:
      begin
        reg_read = '0;
        reg_read[lps_pkg::STAT_LIGHT_BIT] = stat_light_reg;
        reg_read[lps_pkg::STAT_PROX_BIT] = stat_prox_reg;
      end
      lps_pkg::OFS_PRES: reg_read = prox_result_reg;
      lps_pkg::OFS_INT_SETUP: reg_read = int_setup_reg;
      lps_pkg::OFS_PROX_THR: reg_read = prox_thr_reg;
      lps_pkg::OFS_LUP_LO: reg_read = light_upper_reg[7:0];
      lps_pkg::OFS_LUP_HI: reg_read = light_upper_reg[15:8];
      lps_pkg::OFS_LLO_LO: reg_read = light_lower_reg[7:0];
      lps_pkg::OFS_LLO_HI: reg_read = light_lower_reg[15:8];
      default: reg_read = lps_pkg::READ_UNMAPPED;
    endcase
  endfunction : reg_read

  // measurement scheduling
  assign meas.run[lps_pkg::CH_LIGHT] = is_free_run(light_ctrl_reg);
  assign meas.run[lps_pkg::CH_PROX] = is_free_run(prox_ctrl_reg);
  assign meas.rate[lps_pkg::CH_LIGHT] = light_rate_reg[lps_pkg::RATE_W-1:0];
  assign meas.rate[lps_pkg::CH_PROX] = prox_rate_reg[lps_pkg::RATE_W-1:0];
  assign light_tick = meas.tick[lps_pkg::CH_LIGHT];
  assign prox_tick = meas.tick[lps_pkg::CH_PROX];

  // pin edges and bus conditions
  assign scl_rise = scl_in & ~scl_q_reg;
  assign scl_fall = ~scl_in & scl_q_reg;
  assign start_cond = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
  assign stop_cond = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
  assign rd_byte = reg_read(index_reg);
  assign sda_out = 1'b0;
  assign sda_oe = sda_drive_reg;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end
    else
    begin
      scl_q_reg <= scl_in;
      sda_q_reg <= sda_in;
    end
  end

  // byte-level target engine
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= lps_pkg::ST_IDLE;
      after_reg <= lps_pkg::ST_IDLE;
      shift_reg <= '0;
      bit_cnt_reg <= '0;
      got_reg <= 1'b0;
      sda_drive_reg <= 1'b0;
      index_reg <= '0;
      wr_pulse_reg <= 1'b0;
      wr_idx_reg <= '0;
      wr_data_reg <= '0;
      status_read <= 1'b0;
    end
    else
    begin
      wr_pulse_reg <= 1'b0;
      status_read <= 1'b0;
      if (start_cond)
      begin
        // start and repeated start restart address reception
        state_reg <= lps_pkg::ST_ADDR;
        bit_cnt_reg <= '0;
        got_reg <= 1'b0;
        sda_drive_reg <= 1'b0;
      end
      else if (stop_cond)
      begin
        state_reg <= lps_pkg::ST_IDLE;
        sda_drive_reg <= 1'b0;
      end
      else
      begin
        unique case (state_reg)
          lps_pkg::ST_IDLE:
          begin
            sda_drive_reg <= 1'b0;
          end
          lps_pkg::ST_ADDR, lps_pkg::ST_INDEX, lps_pkg::ST_WRITE:
          begin
            if (scl_rise)
            begin
              shift_reg <= {shift_reg[6:0], sda_in};
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
              got_reg <= (bit_cnt_reg == 3'h7);
            end
            else if (scl_fall && got_reg)
            begin
              got_reg <= 1'b0;
              sda_drive_reg <= 1'b1;
              state_reg <= lps_pkg::ST_ACK;
              if (state_reg == lps_pkg::ST_ADDR)
              begin
                if (shift_reg[7:1] != lps_pkg::I2C_ADDR)
                begin
                  // not addressed: stay off the bus until the next start
                  sda_drive_reg <= 1'b0;
                  state_reg <= lps_pkg::ST_IDLE;
                end
                after_reg <= shift_reg[0] ? lps_pkg::ST_READ : lps_pkg::ST_INDEX;
              end
              else if (state_reg == lps_pkg::ST_INDEX)
              begin
                index_reg <= shift_reg;
                after_reg <= lps_pkg::ST_WRITE;
              end
              else
              begin
                wr_pulse_reg <= 1'b1;
                wr_idx_reg <= index_reg;
                wr_data_reg <= shift_reg;
                index_reg <= index_reg + 1'b1;
                after_reg <= lps_pkg::ST_WRITE;
              end
            end
          end
          lps_pkg::ST_ACK, lps_pkg::ST_RACK:
          begin
            if (scl_rise && state_reg == lps_pkg::ST_RACK)
            begin
              got_reg <= ~sda_in;
            end
            else if (scl_fall)
            begin
              bit_cnt_reg <= '0;
              sda_drive_reg <= 1'b0;
              state_reg <= after_reg;
              if (state_reg == lps_pkg::ST_RACK && !got_reg)
              begin
                // not-acknowledge ends the read
                state_reg <= lps_pkg::ST_IDLE;
              end
              else if (after_reg == lps_pkg::ST_READ)
              begin
                shift_reg <= {rd_byte[6:0], 1'b0};
                sda_drive_reg <= ~rd_byte[7];
                status_read <= (index_reg == lps_pkg::OFS_STATUS);
                index_reg <= index_reg + 1'b1;
              end
              got_reg <= 1'b0;
            end
          end
          lps_pkg::ST_READ:
          begin
            if (scl_fall)
            begin
              if (bit_cnt_reg == 3'h7)
              begin
                sda_drive_reg <= 1'b0;
                state_reg <= lps_pkg::ST_RACK;
                after_reg <= lps_pkg::ST_READ;
              end
              else
              begin
                sda_drive_reg <= ~shift_reg[7];
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // writable registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      light_ctrl_reg <= lps_pkg::REG_RESET;
      prox_ctrl_reg <= lps_pkg::REG_RESET;
      emit_cfg_reg <= lps_pkg::REG_RESET;
      prox_rate_reg <= lps_pkg::REG_RESET;
      light_rate_reg <= lps_pkg::REG_RESET;
      int_setup_reg <= lps_pkg::REG_RESET;
      prox_thr_reg <= lps_pkg::REG_RESET;
      light_upper_reg <= {lps_pkg::REG_RESET, lps_pkg::REG_RESET};
      light_lower_reg <= {lps_pkg::REG_RESET, lps_pkg::REG_RESET};
    end
    else if (wr_pulse_reg)
    begin
      unique case (wr_idx_reg)
        lps_pkg::OFS_LIGHT_CTRL: light_ctrl_reg <= wr_data_reg;
        lps_pkg::OFS_PROX_CTRL: prox_ctrl_reg <= wr_data_reg;
        lps_pkg::OFS_EMIT_CFG: emit_cfg_reg <= wr_data_reg;
        lps_pkg::OFS_PROX_RATE: prox_rate_reg <= wr_data_reg;
        lps_pkg::OFS_LIGHT_RATE: light_rate_reg <= wr_data_reg;
        lps_pkg::OFS_INT_SETUP: int_setup_reg <= wr_data_reg;
        lps_pkg::OFS_PROX_THR: prox_thr_reg <= wr_data_reg;
        lps_pkg::OFS_LUP_LO: light_upper_reg[7:0] <= wr_data_reg;
        lps_pkg::OFS_LUP_HI: light_upper_reg[15:8] <= wr_data_reg;
        lps_pkg::OFS_LLO_LO: light_lower_reg[7:0] <= wr_data_reg;
        lps_pkg::OFS_LLO_HI: light_lower_reg[15:8] <= wr_data_reg;
        default: ;
      endcase
    end
  end

  // result capture at each measurement tick
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      light_result_reg <= '0;
      prox_result_reg <= '0;
      light_start_reg <= 1'b0;
      prox_start_reg <= 1'b0;
    end
    else
    begin
      light_start_reg <= light_tick;
      prox_start_reg <= prox_tick;
      if (light_tick)
      begin
        light_result_reg <= light_sample;
      end
      if (prox_tick)
      begin
        // converter delivers the logarithmic code, stored unchanged
        prox_result_reg <= prox_sample;
      end
    end
  end

  // threshold comparison of the incoming samples
  assign transparent = int_setup_reg[lps_pkg::INT_TRANSP_BIT];
  assign invert_eff = transparent & int_setup_reg[lps_pkg::INT_INVERT_BIT];
  assign light_outside = (light_sample < light_lower_reg) || (light_sample > light_upper_reg);
  assign light_hit = invert_eff ? ~light_outside : light_outside;
  assign prox_hit = invert_eff ? (prox_sample < prox_thr_reg) : (prox_sample > prox_thr_reg);

  // status flags: latched until status read, or following each result when transparent
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stat_light_reg <= 1'b0;
      stat_prox_reg <= 1'b0;
    end
    else
    begin
      if (light_tick && int_setup_reg[lps_pkg::INT_LIGHT_EN_BIT] && light_hit)
      begin
        stat_light_reg <= 1'b1;
      end
      else if (!int_setup_reg[lps_pkg::INT_LIGHT_EN_BIT] || (transparent && light_tick))
      begin
        stat_light_reg <= 1'b0;
      end
      else if (status_read && !transparent)
      begin
        stat_light_reg <= 1'b0;
      end
      if (prox_tick && int_setup_reg[lps_pkg::INT_PROX_EN_BIT] && prox_hit)
      begin
        stat_prox_reg <= 1'b1;
      end
      else if (!int_setup_reg[lps_pkg::INT_PROX_EN_BIT] || (transparent && prox_tick))
      begin
        stat_prox_reg <= 1'b0;
      end
      else if (status_read && !transparent)
      begin
        stat_prox_reg <= 1'b0;
      end
    end
  end

  // pin pulled low while any flag stands
  assign int_n_out = 1'b0;
  assign int_n_oe = stat_light_reg | stat_prox_reg;
  assign light_conv_start = light_start_reg;
  assign prox_conv_start = prox_start_reg;
  assign emitter_current = emit_cfg_reg;
endmodule : lps_top

/* File: lps_pkg.sv */
// constants, register map and types for the light and proximity sensor register block
package lps_pkg;
  // target address on the two-wire bus
  localparam logic [6:0] I2C_ADDR = 7'h38;
  // register offsets
  localparam logic [7:0] OFS_LIGHT_CTRL = 8'h80;
  localparam logic [7:0] OFS_PROX_CTRL = 8'h81;
  localparam logic [7:0] OFS_EMIT_CFG = 8'h82;
  localparam logic [7:0] OFS_PROX_RATE = 8'h85;
  localparam logic [7:0] OFS_LIGHT_RATE = 8'h86;
  localparam logic [7:0] OFS_LRES_LO = 8'h8C;
  localparam logic [7:0] OFS_LRES_HI = 8'h8D;
  localparam logic [7:0] OFS_STATUS = 8'h8E;
  localparam logic [7:0] OFS_PRES = 8'h8F;
  localparam logic [7:0] OFS_INT_SETUP = 8'h92;
  localparam logic [7:0] OFS_PROX_THR = 8'h93;
  localparam logic [7:0] OFS_LUP_LO = 8'h96;
  localparam logic [7:0] OFS_LUP_HI = 8'h97;
  localparam logic [7:0] OFS_LLO_LO = 8'h98;
  localparam logic [7:0] OFS_LLO_HI = 8'h99;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // measurement control field
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 2;
  localparam logic [1:0] MODE_FREE_RUN = 2'h3;
  // rate field: period is the base period times (field + 1)
  localparam int RATE_W = 3;
  // interrupt setup fields
  localparam int INT_PROX_EN_BIT = 0;
  localparam int INT_LIGHT_EN_BIT = 1;
  localparam int INT_TRANSP_BIT = 2;
  localparam int INT_INVERT_BIT = 3;
  // status fields
  localparam int STAT_LIGHT_BIT = 7;
  localparam int STAT_PROX_BIT = 6;
  // measurement channels
  localparam int CH_LIGHT = 0;
  localparam int CH_PROX = 1;
  localparam int NUM_CH = 2;
  // timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned LIGHT_PERIOD_MS = 100;
  localparam int unsigned PROX_PERIOD_MS = 10;
  localparam int unsigned LIGHT_PERIOD_CYC = LIGHT_PERIOD_MS * (CLK_HZ / MS_PER_S);
  localparam int unsigned PROX_PERIOD_CYC = PROX_PERIOD_MS * (CLK_HZ / MS_PER_S);
  localparam int CNT_W = 32;
  // serial engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_INDEX,
    ST_WRITE,
    ST_ACK,
    ST_READ,
    ST_RACK
  } lps_i2c_state_t;
endpackage : lps_pkg

/* File: lps_meas_if.sv */
// handshake between register block and measurement scheduler
`timescale 1ns/1ns
interface lps_meas_if;
  logic [lps_pkg::NUM_CH-1:0] run;
  logic [lps_pkg::RATE_W-1:0] rate [lps_pkg::NUM_CH];
  logic [lps_pkg::NUM_CH-1:0] tick;
  modport ctrl (output run, output rate, input tick);
  modport sched (input run, input rate, output tick);
endinterface : lps_meas_if

/* File: lps_meas_sched.sv */
// free-running measurement period generator, one per channel
`timescale 1ns/1ns
module lps_meas_sched #(
  parameter int unsigned LIGHT_CYC = lps_pkg::LIGHT_PERIOD_CYC,
  parameter int unsigned PROX_CYC = lps_pkg::PROX_PERIOD_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // control side
  lps_meas_if.sched meas
);
  genvar ch;
  generate
    for (ch = 0; ch < lps_pkg::NUM_CH; ch++)
    begin : g_ch
      localparam int unsigned BASE = (ch == lps_pkg::CH_LIGHT) ? LIGHT_CYC : PROX_CYC;
      logic [lps_pkg::CNT_W-1:0] cnt_reg;
      logic tick_reg;
      logic [lps_pkg::CNT_W-1:0] limit;
      assign limit = lps_pkg::CNT_W'(BASE * (32'(meas.rate[ch]) + 32'h1) - 32'h1);
      assign meas.tick[ch] = tick_reg;
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          cnt_reg <= '0;
          tick_reg <= 1'b0;
        end
        else if (!meas.run[ch])
        begin
          cnt_reg <= '0;
          tick_reg <= 1'b0;
        end
        else if (cnt_reg >= limit)
        begin
          // one result per period in free-running mode
          cnt_reg <= '0;
          tick_reg <= 1'b1;
        end
        else
        begin
          cnt_reg <= cnt_reg + 1'b1;
          tick_reg <= 1'b0;
        end
      end
    end
  endgenerate
endmodule : lps_meas_sched

/* File: lps_top_chk.sv */
// port-level assertion checker for the sensor register block
`timescale 1ns/1ns
module lps_top_chk #(
  parameter int unsigned LIGHT_PERIOD_CYC = lps_pkg::LIGHT_PERIOD_CYC,
  parameter int unsigned PROX_PERIOD_CYC = lps_pkg::PROX_PERIOD_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // interrupt pin
  input wire logic int_n_out,
  input wire logic int_n_oe,
  // converter side
  input wire logic [15:0] light_sample,
  input wire logic [7:0] prox_sample,
  input wire logic light_conv_start,
  input wire logic prox_conv_start,
  input wire logic [7:0] emitter_current
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // cycles since the previous conversion start, 0 until the first one
  int unsigned lgap;
  int unsigned pgap;
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      lgap <= 0;
    else if (light_conv_start)
      lgap <= 1;
    else if (lgap != 0)
      lgap <= lgap + 1;
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      pgap <= 0;
    else if (prox_conv_start)
      pgap <= 1;
    else if (pgap != 0)
      pgap <= pgap + 1;
  sequence s_scl_steady;
    scl_in ##1 scl_in ##1 scl_in;
  endsequence
  sequence s_tick;
    light_conv_start || prox_conv_start;
  endsequence
  a_sda_drive_low: assert property (sda_out == 1'b0)
    else $error("data pin value not low");
  a_int_drive_low: assert property (int_n_out == 1'b0)
    else $error("interrupt pin value not low");
  a_sda_steady_high: assert property (s_scl_steady |-> $stable(sda_oe))
    else $error("data drive changed while clock high");
  a_ack_in_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data drive started while clock high");
  a_light_one_pulse: assert property (light_conv_start |=> !light_conv_start)
    else $error("light start longer than one cycle");
  a_prox_one_pulse: assert property (prox_conv_start |=> !prox_conv_start)
    else $error("proximity start longer than one cycle");
  a_light_period: assert property (light_conv_start && lgap != 0 |-> lgap >= LIGHT_PERIOD_CYC)
    else $error("light period too short");
  a_prox_period: assert property (prox_conv_start && pgap != 0 |-> pgap >= PROX_PERIOD_CYC)
    else $error("proximity period too short");
  a_int_set_tick: assert property ($rose(int_n_oe) |-> s_tick)
    else $error("interrupt raised without a measurement");
  a_int_latch_hold: assert property ($fell(int_n_oe) |-> light_conv_start || prox_conv_start
    || sda_oe || $past(sda_oe) || $past(sda_oe, 2))
    else $error("interrupt dropped without cause");
endmodule : lps_top_chk

bind lps_top lps_top_chk #(
  .LIGHT_PERIOD_CYC(LIGHT_PERIOD_CYC),
  .PROX_PERIOD_CYC(PROX_PERIOD_CYC)
) u_chk (
  .core_clk(core_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe),
  .light_sample(light_sample), .prox_sample(prox_sample),
  .light_conv_start(light_conv_start), .prox_conv_start(prox_conv_start),
  .emitter_current(emitter_current)
);

/* File: lps_host.sv */
// two-wire host model that reaches the sensor registers
`timescale 1ns/1ns
module lps_host (
  // clock
  input wire logic core_clk,
  // bus pins, data released means pulled up
  output logic scl,
  output logic sda_rel,
  input wire logic sda_line
);
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // each clock phase lasts four core cycles
  task automatic hp;
    repeat (4) @(negedge core_clk);
  endtask : hp
  task automatic start;
    hp();
    sda_rel = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_rel = 1'b0;
    hp();
    scl = 1'b0;
  endtask : start
  task automatic stop;
    hp();
    sda_rel = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_rel = 1'b1;
    hp();
  endtask : stop
  // nine clocks: eight bits msb first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] r,
    output logic k);
    for (int i = 7; i >= -1; i--)
    begin
      sda_rel = (i < 0) ? a : d[i];
      hp();
      scl = 1'b1;
      hp();
      if (i < 0)
        k = sda_line;
      else
        r[i] = sda_line;
      scl = 1'b0;
    end
  endtask : byte_io
  task automatic xfer(input logic [6:0] adr, input logic rd, input logic [7:0] idx,
    input logic [7:0] wd, output logic [7:0] rdat, output logic ok);
    logic [7:0] x;
    logic k0;
    logic k1;
    logic k2;
    logic k3;
    k1 = 1'b1;
    k2 = 1'b1;
    rdat = 8'h00;
    start();
    byte_io({adr, 1'b0}, 1'b1, x, k0);
    if (!k0)
    begin
      byte_io(idx, 1'b1, x, k1);
      if (rd)
      begin
        start();
        byte_io({adr, 1'b1}, 1'b1, x, k2);
        byte_io(8'hFF, 1'b1, rdat, k3);
      end
      else
        byte_io(wd, 1'b1, x, k2);
    end
    stop();
    ok = !(k0 | k1 | k2);
  endtask : xfer
endmodule : lps_host

/* File: lps_top_bench.sv */
// self-checking bench for the light and proximity sensor register block
`timescale 1ns/1ns
module lps_top_bench;
  localparam int unsigned LCYC = 40;
  localparam int unsigned PCYC = 20;
  localparam logic [7:0] OFS [11] = '{8'h80, 8'h86, 8'h98, 8'h99, 8'h96, 8'h97, 8'h81,
    8'h82, 8'h85, 8'h93, 8'h92};
  localparam logic [7:0] VAL [11] = '{8'h03, 8'h00, 8'h00, 8'h10, 8'h00, 8'h20, 8'h03,
    8'h1E, 8'h00, 8'h40, 8'h03};
  logic core_clk;
  logic nrst;
  logic scl;
  logic sda_rel;
  logic sda_line;
  logic sda_oe;
  logic int_n_oe;
  logic light_conv_start;
  logic prox_conv_start;
  logic [7:0] emitter_current;
  logic [15:0] light_sample;
  logic [7:0] prox_sample;
  int n_fail;
  int check_count;
  int cyc;
  // pull-up on the shared data line
  assign sda_line = sda_rel & ~sda_oe;
  lps_top #(.LIGHT_PERIOD_CYC(LCYC), .PROX_PERIOD_CYC(PCYC)) u_dut (
    .core_clk(core_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line), .sda_out(),
    .sda_oe(sda_oe), .int_n_out(), .int_n_oe(int_n_oe), .light_sample(light_sample),
    .prox_sample(prox_sample), .light_conv_start(light_conv_start),
    .prox_conv_start(prox_conv_start), .emitter_current(emitter_current));
  lps_host u_host (.core_clk(core_clk), .scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));
  task automatic complete_run;
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask : chk1
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic ok;
    u_host.xfer(lps_pkg::I2C_ADDR, 1'b0, idx, d, r, ok);
    chk1(ok, 1'b1, "write ack");
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    logic ok;
    u_host.xfer(lps_pkg::I2C_ADDR, 1'b1, idx, 8'h00, r, ok);
    chk1(ok, 1'b1, "read ack");
    chk8(r, exp, "read data");
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : settle
  task automatic wait_int(input logic e);
    for (int i = 0; i < 4 * LCYC && int_n_oe !== e; i++)
      @(negedge core_clk);
    chk1(int_n_oe, e, "int pin");
  endtask : wait_int
  // cycles between two conversion starts of one channel
  task automatic gap(input logic p, output int n);
    n = 0;
    while ((p ? prox_conv_start : light_conv_start) !== 1'b1 && n < 500)
    begin
      @(negedge core_clk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while ((p ? prox_conv_start : light_conv_start) !== 1'b1 && n < 500);
  endtask : gap
  task automatic t_reset;
    logic [7:0] r;
    logic ok;
    chk1(int_n_oe, 1'b0, "int idle");
    chk8(emitter_current, 8'h00, "emitter reset");
    foreach (OFS[i])
      rd(OFS[i], 8'h00);
    rd(8'h83, 8'h00);
    u_host.xfer(7'h39, 1'b1, 8'h80, 8'h00, r, ok);
    chk1(ok, 1'b0, "foreign address");
  endtask : t_reset
  task automatic t_config;
    int n;
    foreach (OFS[i])
      wr(OFS[i], VAL[i]);
    foreach (OFS[i])
      rd(OFS[i], VAL[i]);
    chk8(emitter_current, 8'h1E, "emitter code");
    wr(8'h83, 8'h55);
    rd(8'h83, 8'h00);
    gap(1'b0, n);
    chk8(8'(n), 8'(LCYC), "light period");
    gap(1'b1, n);
    chk8(8'(n), 8'(PCYC), "prox period");
    wr(8'h85, 8'h01);
    gap(1'b1, n);
    chk8(8'(n), 8'(2 * PCYC), "prox rate");
    wr(8'h85, 8'h00);
    rd(8'h8C, 8'h5B);
    rd(8'h8D, 8'h1A);
    wr(8'h8F, 8'hFF);
    rd(8'h8F, 8'h33);
    chk1(int_n_oe, 1'b0, "inside window");
  endtask : t_config
  task automatic t_light_latch;
    light_sample = 16'h2000;
    settle(3 * LCYC);
    chk1(int_n_oe, 1'b0, "at upper");
    light_sample = 16'h2001;
    wait_int(1'b1);
    light_sample = 16'h1800;
    settle(3 * LCYC);
    chk1(int_n_oe, 1'b1, "held");
    rd(8'h8E, 8'h80);
    settle(2 * LCYC);
    chk1(int_n_oe, 1'b0, "released");
    light_sample = 16'h0FFF;
    wait_int(1'b1);
    wr(8'h98, 8'h00);
    wr(8'h99, 8'h0E);
    rd(8'h8E, 8'h80);
    settle(2 * LCYC);
    chk1(int_n_oe, 1'b0, "new window");
  endtask : t_light_latch
  task automatic t_prox_latch;
    prox_sample = 8'h40;
    settle(3 * PCYC);
    chk1(int_n_oe, 1'b0, "at prox limit");
    prox_sample = 8'h41;
    wait_int(1'b1);
    prox_sample = 8'h40;
    rd(8'h8E, 8'h40);
    settle(2 * PCYC);
    chk1(int_n_oe, 1'b0, "prox released");
  endtask : t_prox_latch
  task automatic t_modes;
    light_sample = 16'h1800;
    wr(8'h92, 8'h0E);
    wait_int(1'b1);
    light_sample = 16'h2100;
    wait_int(1'b0);
    wr(8'h92, 8'h06);
    wait_int(1'b1);
    light_sample = 16'h1800;
    wait_int(1'b0);
    prox_sample = 8'h20;
    wr(8'h92, 8'h0D);
    wait_int(1'b1);
    prox_sample = 8'h50;
    wait_int(1'b0);
    rd(8'h8E, 8'h00);
    wr(8'h92, 8'h0A);
    settle(3 * LCYC);
    chk1(int_n_oe, 1'b0, "invert latched");
    light_sample = 16'h3000;
    wait_int(1'b1);
    rd(8'h8E, 8'h80);
    wr(8'h92, 8'h00);
    prox_sample = 8'hF0;
    settle(3 * LCYC);
    chk1(int_n_oe, 1'b0, "disabled");
  endtask : t_modes
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_fail++;
      complete_run();
    end
  end
  initial
  begin
    nrst = 1'b0;
    light_sample = 16'h1A5B;
    prox_sample = 8'h33;
    settle(16);
    nrst = 1'b1;
    settle(2);
    t_reset();
    t_config();
    t_light_latch();
    t_prox_latch();
    t_modes();
    complete_run();
  end
endmodule : lps_top_bench
